// ---- pkg/nsa_defs.svh ----
// Constants of the nonvolatile self-access controller
`ifndef NSA_DEFS_SVH
`define NSA_DEFS_SVH

// ****************************
// Register offsets
// ****************************
`define NSA_OFF_DATA_LOW 9'h10c
`define NSA_OFF_ADDR_LOW 9'h10d
`define NSA_OFF_DATA_HIGH 9'h10e
`define NSA_OFF_ADDR_HIGH 9'h10f
`define NSA_OFF_CONTROL 9'h18c
`define NSA_OFF_UNLOCK 9'h18d

// ****************************
// Control fields
// ****************************
`define NSA_CTL_RD 0
`define NSA_CTL_WR 1
`define NSA_CTL_WREN 2
`define NSA_CTL_SEL 7

// ****************************
// Reset values and keys
// ****************************
`define NSA_RST_BYTE 8'h00
`define NSA_UNLOCK_FIRST 8'h55
`define NSA_UNLOCK_SECOND 8'haa

// ****************************
// Sizes and timing
// ****************************
`define NSA_EE_DEPTH 64
`define NSA_PF_DEPTH 2048
`define NSA_PF_WIDTH 14
`define NSA_CLK_PERIOD_NS 10
`define NSA_WRITE_TIME_NS 4000000
`define NSA_WRITE_CYCLES ((`NSA_WRITE_TIME_NS) / (`NSA_CLK_PERIOD_NS))
`define NSA_PROG_RD_CYCLES 2

`endif

// ---- pkg/nsa_pkg.sv ----
// Types of the nonvolatile self-access controller
`default_nettype none
package nsa_pkg;
   typedef enum logic [3:0] {
      NSA_IDLE    = 4'b0001,
      NSA_RD_PROG = 4'b0010,
      NSA_WR_DATA = 4'b0100,
      NSA_WR_PROG = 4'b1000
   } nsa_state_e;
   typedef logic [7:0] nsa_byte_t;
endpackage : nsa_pkg
`default_nettype wire

// ---- hw/nsa_storage.sv ----
// Data byte store and program word store
`timescale 1ns/10ps
`default_nettype none
module nsa_storage #(
   parameter int EE_DEPTH = 64,
   parameter int PF_DEPTH = 2048,
   parameter int PF_WIDTH = 14
) (
   input wire logic clk,
   input wire logic ee_we,
   input wire logic [$clog2(EE_DEPTH)-1:0] ee_addr,
   input wire logic [7:0] ee_wdata,
   output logic [7:0] ee_rdata,
   input wire logic pf_we,
   input wire logic [$clog2(PF_DEPTH)-1:0] pf_addr,
   input wire logic [PF_WIDTH-1:0] pf_wdata,
   output logic [PF_WIDTH-1:0] pf_rdata
);
   logic [7:0] ee_mem [EE_DEPTH];
   logic [PF_WIDTH-1:0] pf_mem [PF_DEPTH];

   if (EE_DEPTH < 2 || PF_DEPTH < 2 || PF_WIDTH < 1 || PF_WIDTH > 16) begin
      $error("nsa_storage: unsupported size");
   end

   // ****************************
   // One location replaced per write
   // ****************************
   always_ff @(posedge clk) begin
      if (ee_we) begin
         ee_mem[ee_addr] <= ee_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (pf_we) begin
         pf_mem[pf_addr] <= pf_wdata;
      end
   end

   assign ee_rdata = ee_mem[ee_addr];
   assign pf_rdata = pf_mem[pf_addr];
endmodule : nsa_storage
`default_nettype wire

// ---- hw/nsa_ctrl.sv ----
// Processor-side access controller for data EEPROM and program flash
`timescale 1ns/10ps
`default_nettype none
`include "nsa_defs.svh"

module nsa_ctrl #(
   parameter int WRITE_CYCLES = `NSA_WRITE_CYCLES,
   parameter int EE_DEPTH = `NSA_EE_DEPTH,
   parameter int PF_DEPTH = `NSA_PF_DEPTH
) (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic [8:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   input wire logic INT_EVENT,
   input wire logic INT_ENABLE,
   output logic CORE_STALL,
   output logic INT_VECTOR,
   output logic WRITE_DONE
);
   localparam int TW = $clog2(WRITE_CYCLES + 1);
   localparam int EAW = $clog2(EE_DEPTH);
   localparam int PAW = $clog2(PF_DEPTH);
   localparam logic [TW-1:0] TIMER_LOAD = TW'(WRITE_CYCLES - 1);
   localparam logic [1:0] PRD_LOAD = 2'(`NSA_PROG_RD_CYCLES - 1);

   if (WRITE_CYCLES < 2 || EE_DEPTH < 2 || PF_DEPTH < 2 || PAW > 13) begin
      $error("nsa_ctrl: unsupported parameter value");
   end

   // ****************************
   // Address decode
   // ****************************
   function automatic logic hits(input logic [8:0] a, input logic [8:0] off);
      return a == off;
   endfunction : hits

   nsa_pkg::nsa_state_e state;
   nsa_pkg::nsa_byte_t data_low;
   nsa_pkg::nsa_byte_t addr_low;
   logic [5:0] data_high;
   logic [4:0] addr_high;
   logic memory_select;
   logic wren;
   logic rd;
   logic wr;
   logic seen_first;
   logic armed;
   logic [TW-1:0] timer;
   logic [1:0] rd_cnt;
   logic [PAW-1:0] op_addr;
   logic [13:0] op_data;
   logic release_cyc;
   logic int_queued;
   logic [7:0] ee_rdata;
   logic [13:0] pf_rdata;
   logic ctl_write;
   logic start_wr;
   logic start_rd;
   logic write_end;
   logic [PAW-1:0] pf_addr;
   logic [EAW-1:0] ee_addr;

   assign ctl_write = SFR_WR && hits(SFR_ADDR, `NSA_OFF_CONTROL);
   assign start_wr = ctl_write && SFR_WDATA[`NSA_CTL_WR] && armed
      && (wren || SFR_WDATA[`NSA_CTL_WREN])
      && state == nsa_pkg::NSA_IDLE && !rd && !wr;
   assign start_rd = ctl_write && SFR_WDATA[`NSA_CTL_RD] && !start_wr
      && state == nsa_pkg::NSA_IDLE && !rd && !wr;
   assign write_end = (state == nsa_pkg::NSA_WR_DATA
      || state == nsa_pkg::NSA_WR_PROG) && timer == '0;

   // Wrapped addresses into each store
   assign ee_addr = state == nsa_pkg::NSA_WR_DATA ? op_addr[EAW-1:0]
      : addr_low[EAW-1:0];
   assign pf_addr = state == nsa_pkg::NSA_WR_PROG ? op_addr
      : PAW'({addr_high, addr_low});

   nsa_storage #(
      .EE_DEPTH(EE_DEPTH),
      .PF_DEPTH(PF_DEPTH),
      .PF_WIDTH(`NSA_PF_WIDTH)
   ) u_storage (
      .clk(MCLK),
      .ee_we(write_end && state == nsa_pkg::NSA_WR_DATA),
      .ee_addr(ee_addr),
      .ee_wdata(op_data[7:0]),
      .ee_rdata(ee_rdata),
      .pf_we(write_end && state == nsa_pkg::NSA_WR_PROG),
      .pf_addr(pf_addr),
      .pf_wdata(op_data),
      .pf_rdata(pf_rdata)
   );

   // ****************************
   // Unlock sequence
   // ****************************
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         seen_first <= 1'b0;
         armed <= 1'b0;
      end else if (SFR_WR) begin
         // Only the register write right after the key may use it
         seen_first <= hits(SFR_ADDR, `NSA_OFF_UNLOCK)
            && SFR_WDATA == `NSA_UNLOCK_FIRST;
         armed <= hits(SFR_ADDR, `NSA_OFF_UNLOCK) && seen_first
            && SFR_WDATA == `NSA_UNLOCK_SECOND;
      end
   end

   // ****************************
   // Address and control registers
   // ****************************
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         addr_low <= `NSA_RST_BYTE;
         addr_high <= '0;
      end else if (SFR_WR) begin
         if (hits(SFR_ADDR, `NSA_OFF_ADDR_LOW)) begin
            addr_low <= SFR_WDATA;
         end
         if (hits(SFR_ADDR, `NSA_OFF_ADDR_HIGH)) begin
            addr_high <= SFR_WDATA[4:0];
         end
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         memory_select <= 1'b0;
         wren <= 1'b0;
      end else if (ctl_write) begin
         memory_select <= SFR_WDATA[`NSA_CTL_SEL];
         wren <= SFR_WDATA[`NSA_CTL_WREN];
      end
   end

   // Strobes: set by software, cleared only by hardware
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rd <= 1'b0;
      end else if (start_rd) begin
         rd <= 1'b1;
      end else if (rd && (state == nsa_pkg::NSA_IDLE
            || (state == nsa_pkg::NSA_RD_PROG && rd_cnt == '0))) begin
         rd <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr <= 1'b0;
      end else if (start_wr) begin
         wr <= 1'b1;
      end else if (write_end) begin
         wr <= 1'b0;
      end
   end

   // ****************************
   // Data registers
   // ****************************
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         data_low <= `NSA_RST_BYTE;
         data_high <= '0;
      end else if (rd && state == nsa_pkg::NSA_IDLE) begin
         data_low <= ee_rdata;
      end else if (state == nsa_pkg::NSA_RD_PROG && rd_cnt == '0) begin
         data_low <= pf_rdata[7:0];
         data_high <= pf_rdata[13:8];
      end else if (SFR_WR) begin
         if (hits(SFR_ADDR, `NSA_OFF_DATA_LOW)) begin
            data_low <= SFR_WDATA;
         end
         if (hits(SFR_ADDR, `NSA_OFF_DATA_HIGH)) begin
            data_high <= SFR_WDATA[5:0];
         end
      end
   end

   // ****************************
   // Operation sequencer
   // ****************************
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= nsa_pkg::NSA_IDLE;
         timer <= '0;
         rd_cnt <= '0;
         op_addr <= '0;
         op_data <= '0;
      end else begin
         unique case (state)
            nsa_pkg::NSA_IDLE: begin
               if (start_wr) begin
                  // Snapshot so software may move on during a data write
                  op_addr <= memory_select ? PAW'({addr_high, addr_low})
                     : PAW'(addr_low[EAW-1:0]);
                  op_data <= {data_high, data_low};
                  timer <= TIMER_LOAD;
                  state <= memory_select ? nsa_pkg::NSA_WR_PROG
                     : nsa_pkg::NSA_WR_DATA;
               end else if (start_rd && memory_select) begin
                  rd_cnt <= PRD_LOAD;
                  state <= nsa_pkg::NSA_RD_PROG;
               end
            end
            nsa_pkg::NSA_RD_PROG: begin
               if (rd_cnt == '0) begin
                  state <= nsa_pkg::NSA_IDLE;
               end else begin
                  rd_cnt <= rd_cnt - 2'd1;
               end
            end
            nsa_pkg::NSA_WR_DATA,
            nsa_pkg::NSA_WR_PROG: begin
               if (timer == '0) begin
                  state <= nsa_pkg::NSA_IDLE;
               end else begin
                  timer <= timer - TW'(1);
               end
            end
            default: begin
               state <= nsa_pkg::NSA_IDLE;
            end
         endcase
      end
   end

   // ****************************
   // Core stall and interrupt queue
   // ****************************
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CORE_STALL <= 1'b0;
         release_cyc <= 1'b0;
      end else begin
         if (start_wr && memory_select) begin
            CORE_STALL <= 1'b1;
         end else if (write_end) begin
            CORE_STALL <= 1'b0;
         end
         release_cyc <= write_end && state == nsa_pkg::NSA_WR_PROG;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         int_queued <= 1'b0;
         INT_VECTOR <= 1'b0;
      end else begin
         if (CORE_STALL && INT_EVENT) begin
            int_queued <= 1'b1;
         end else if (release_cyc) begin
            int_queued <= 1'b0;
         end
         INT_VECTOR <= release_cyc && int_queued && INT_ENABLE;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         WRITE_DONE <= 1'b0;
      end else begin
         WRITE_DONE <= write_end;
      end
   end

   // ****************************
   // Register read port
   // ****************************
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SFR_RDATA <= '0;
      end else if (SFR_RD) begin
         unique case (1'b1)
            hits(SFR_ADDR, `NSA_OFF_DATA_LOW): SFR_RDATA <= data_low;
            hits(SFR_ADDR, `NSA_OFF_ADDR_LOW): SFR_RDATA <= addr_low;
            hits(SFR_ADDR, `NSA_OFF_DATA_HIGH): SFR_RDATA <= {2'h0, data_high};
            hits(SFR_ADDR, `NSA_OFF_ADDR_HIGH): SFR_RDATA <= {3'h0, addr_high};
            hits(SFR_ADDR, `NSA_OFF_CONTROL): begin
               SFR_RDATA <= {memory_select, 4'h0, wren, wr, rd};
            end
            default: SFR_RDATA <= '0;
         endcase
      end
   end

   // ****************************
   // Checks
   // ****************************
   sequence prog_read_s;
      rd [*2] ##1 !rd;
   endsequence

   sequence stall_release_s;
      !INT_VECTOR ##1 INT_VECTOR;
   endsequence

   ee_read_next_a: assert property (
      @(posedge MCLK) disable iff (!ARST_N)
      start_rd && !memory_select |=> ##1 !rd && data_low == $past(ee_rdata))
      else $error("data read not ready next cycle");

   prog_read_delay_a: assert property (
      @(posedge MCLK) disable iff (!ARST_N)
      start_rd && memory_select |=> prog_read_s)
      else $error("program read latency wrong");

   prog_read_free_a: assert property (
      @(posedge MCLK) disable iff (!ARST_N)
      state == nsa_pkg::NSA_RD_PROG |-> !CORE_STALL)
      else $error("program read stalled the core");

   data_write_free_a: assert property (
      @(posedge MCLK) disable iff (!ARST_N)
      state == nsa_pkg::NSA_WR_DATA |-> !CORE_STALL)
      else $error("data write stalled the core");

   prog_write_halt_a: assert property (
      @(posedge MCLK) disable iff (!ARST_N)
      start_wr && memory_select |=> CORE_STALL throughout wr[*2])
      else $error("program write did not halt core");

   unlock_guard_a: assert property (
      @(posedge MCLK) disable iff (!ARST_N)
      $rose(wr) |-> $past(armed) && $past(SFR_WR))
      else $error("write started without unlock");

   timer_done_a: assert property (
      @(posedge MCLK) disable iff (!ARST_N)
      write_end |=> WRITE_DONE && !wr && state == nsa_pkg::NSA_IDLE)
      else $error("write completion not reported");

   read_strobe_hold_a: assert property (
      @(posedge MCLK) disable iff (!ARST_N)
      rd && state == nsa_pkg::NSA_RD_PROG && rd_cnt != '0 |=> rd)
      else $error("read strobe cleared early");

   int_after_next_a: assert property (
      @(posedge MCLK) disable iff (!ARST_N)
      $fell(CORE_STALL) && int_queued && INT_ENABLE |-> stall_release_s)
      else $error("queued interrupt not taken in order");
endmodule : nsa_ctrl
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking testbench of the nonvolatile self-access controller
`timescale 1ns/10ps
`default_nettype none
`include "nsa_defs.svh"
module tb_top;
   // ****************************
   // Signals and models
   // ****************************
   localparam int WC = 8;
   localparam logic [8:0] T_ADDR [5] = '{`NSA_OFF_DATA_HIGH,
      `NSA_OFF_ADDR_HIGH, `NSA_OFF_CONTROL, `NSA_OFF_UNLOCK, 9'h100};
   localparam logic [7:0] T_WDATA [5] = '{8'hff, 8'hff, 8'hfc, 8'h55, 8'hff};
   localparam logic [7:0] T_EXP [5] = '{8'h3f, 8'h1f, 8'h84, 8'h00, 8'h00};
   logic MCLK;
   logic ARST_N;
   logic [8:0] SFR_ADDR;
   logic SFR_WR;
   logic SFR_RD;
   logic [7:0] SFR_WDATA;
   logic [7:0] SFR_RDATA;
   logic INT_EVENT;
   logic INT_ENABLE;
   logic CORE_STALL;
   logic INT_VECTOR;
   logic WRITE_DONE;
   int mismatches;
   int n_tests;
   logic [7:0] ee_m [int];
   logic [13:0] pf_m [int];

   nsa_ctrl #(.WRITE_CYCLES(WC)) u_nsa_ctrl (
      .MCLK(MCLK),
      .ARST_N(ARST_N),
      .SFR_ADDR(SFR_ADDR),
      .SFR_WR(SFR_WR),
      .SFR_RD(SFR_RD),
      .SFR_WDATA(SFR_WDATA),
      .SFR_RDATA(SFR_RDATA),
      .INT_EVENT(INT_EVENT),
      .INT_ENABLE(INT_ENABLE),
      .CORE_STALL(CORE_STALL),
      .INT_VECTOR(INT_VECTOR),
      .WRITE_DONE(WRITE_DONE)
   );

   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end

   // ****************************
   // Checking and closing
   // ****************************
   task automatic chk(input string what, input logic [13:0] seen,
      input logic [13:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic finish_test();
      if (mismatches == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   function automatic logic [13:0] exp_word(input logic sel,
      input logic [7:0] ah, input logic [7:0] al);
      if (sel) begin
         return pf_m[{ah[2:0], al}];
      end
      return {6'h00, ee_m[al[5:0]]};
   endfunction : exp_word

   // ****************************
   // Register bus tasks
   // ****************************
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge MCLK);
      #1;
      SFR_ADDR = a;
      SFR_WDATA = d;
      SFR_WR = 1'b1;
      @(posedge MCLK);
      #1;
      SFR_WR = 1'b0;
   endtask : wr

   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge MCLK);
      #1;
      SFR_ADDR = a;
      SFR_RD = 1'b1;
      @(posedge MCLK);
      #1;
      SFR_RD = 1'b0;
      d = SFR_RDATA;
   endtask : rd

   // Mode 0 legal, 1 wrong second key, 2 write enable missing
   task automatic do_write(input logic sel, input logic [7:0] ah,
      input logic [7:0] al, input logic [13:0] w, input logic ie,
      input int mode);
      int n;
      logic [7:0] c;
      logic ok;
      ok = (mode == 0);
      wr(`NSA_OFF_CONTROL, {sel, 7'h00});
      wr(`NSA_OFF_ADDR_HIGH, ah);
      wr(`NSA_OFF_ADDR_LOW, al);
      wr(`NSA_OFF_DATA_HIGH, {2'b00, w[13:8]});
      wr(`NSA_OFF_DATA_LOW, w[7:0]);
      wr(`NSA_OFF_UNLOCK, `NSA_UNLOCK_FIRST);
      wr(`NSA_OFF_UNLOCK, (mode == 1) ? 8'h5a : `NSA_UNLOCK_SECOND);
      INT_ENABLE = ie;
      wr(`NSA_OFF_CONTROL, {sel, 4'h0, (mode != 2), 1'b1, 1'b0});
      chk("stall_start", CORE_STALL, sel && ok);
      INT_EVENT = 1'b1;
      n = 0;
      while (WRITE_DONE !== 1'b1 && n < WC + 6) begin
         @(posedge MCLK);
         #1;
         INT_EVENT = 1'b0;
         if (WRITE_DONE !== 1'b1) begin
            chk("stall_hold", CORE_STALL, sel && ok);
         end
         n++;
      end
      chk("done", WRITE_DONE, ok);
      if (ok) begin
         chk("write_time", n >= WC - 1 && n <= WC + 2, 1'b1);
      end
      chk("stall_end", CORE_STALL, 1'b0);
      chk("vector_early", INT_VECTOR, 1'b0);
      @(posedge MCLK);
      #1;
      chk("vector", INT_VECTOR, sel && ie && ok);
      rd(`NSA_OFF_CONTROL, c);
      chk("ctl_wr", c[1], 1'b0);
      if (ok && sel) begin
         pf_m[{ah[2:0], al}] = w;
      end else if (ok) begin
         ee_m[al[5:0]] = w[7:0];
      end
   endtask : do_write

   task automatic check_mem(input logic sel, input logic [7:0] ah,
      input logic [7:0] al);
      logic [7:0] c;
      logic [7:0] dl;
      logic [7:0] dh;
      logic [13:0] e;
      e = exp_word(sel, ah, al);
      wr(`NSA_OFF_CONTROL, {sel, 7'h00});
      wr(`NSA_OFF_ADDR_HIGH, ah);
      wr(`NSA_OFF_ADDR_LOW, al);
      wr(`NSA_OFF_CONTROL, {sel, 7'h01});
      chk("rd_stall", CORE_STALL, 1'b0);
      rd(`NSA_OFF_CONTROL, c);
      chk("ctl_rd", c, {sel, 6'h00, sel});
      rd(`NSA_OFF_DATA_LOW, dl);
      rd(`NSA_OFF_DATA_HIGH, dh);
      if (sel) begin
         chk("pf_word", {dh[5:0], dl}, e);
      end else begin
         chk("ee_byte", dl, e[7:0]);
      end
   endtask : check_mem

   // ****************************
   // Main sequence
   // ****************************
   initial begin
      logic [7:0] v;
      logic [7:0] ah;
      logic [7:0] al;
      logic [13:0] w;
      logic s;
      ARST_N = 1'b0;
      SFR_ADDR = 9'h000;
      SFR_WR = 1'b0;
      SFR_RD = 1'b0;
      SFR_WDATA = 8'h00;
      INT_EVENT = 1'b0;
      INT_ENABLE = 1'b0;
      void'($urandom(73));
      repeat (3) @(posedge MCLK);
      #1;
      ARST_N = 1'b1;
      rd(`NSA_OFF_DATA_LOW, v);
      chk("rst_data_low", v, 8'h00);
      rd(`NSA_OFF_ADDR_LOW, v);
      chk("rst_addr_low", v, 8'h00);
      rd(`NSA_OFF_CONTROL, v);
      chk("rst_control", v, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(T_ADDR[i], T_WDATA[i]);
         rd(T_ADDR[i], v);
         chk("access", v, T_EXP[i]);
      end
      wr(`NSA_OFF_CONTROL, 8'h00);
      do_write(1'b0, 8'h00, 8'h40, 14'h00a5, 1'b1, 0);
      check_mem(1'b0, 8'h00, 8'h00);
      do_write(1'b1, 8'h08, 8'h00, 14'h3fff, 1'b1, 0);
      check_mem(1'b1, 8'h00, 8'h00);
      do_write(1'b1, 8'h00, 8'h00, 14'h1234, 1'b1, 1);
      check_mem(1'b1, 8'h00, 8'h00);
      do_write(1'b0, 8'h00, 8'h00, 14'h0011, 1'b0, 2);
      check_mem(1'b0, 8'h00, 8'h00);
      repeat (10) begin
         s = 1'($urandom_range(0, 1));
         ah = 8'($urandom);
         al = 8'($urandom);
         w = 14'($urandom);
         do_write(s, ah, al, w, 1'($urandom_range(0, 1)), 0);
         check_mem(s, ah, al);
      end
      finish_test();
   end

   initial begin
      repeat (100000) @(posedge MCLK);
      mismatches++;
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
